// File: core/rpsc_pkg.sv
// Package for the redistributor power and scrub control block.
// Assumes an AXI4-Lite slave with 32-bit data and byte addresses.
package rpsc_pkg;
	localparam logic [11:0] OFS_FUNCTION_CONTROL = 12'h000;
	localparam logic [11:0] OFS_POWER_CONTROL = 12'h004;
	localparam logic [11:0] OFS_INTERRUPT_CLASS = 12'h008;
	localparam logic [11:0] OFS_WAKE_REGISTER = 12'h00c;
	localparam int FC_SCRUB_BIT = 0;
	localparam int FC_DENY_BIT = 1;
	localparam int FC_CGO_LO = 2;
	localparam int FC_CGO_HI = 4;
	localparam int PW_PERMIT_BIT = 0;
	localparam int PW_APPLY_BIT = 1;
	localparam int PW_INTENT_BIT = 2;
	localparam int PW_OFF_BIT = 3;
	localparam int PW_CORE_LO = 8;
	localparam int PW_CORE_HI = 14;
	localparam int PW_GRP_LO = 15;
	localparam int PW_GRP_HI = 23;
	localparam int WK_SLEEP_BIT = 1;
	localparam int CLASS_BIT = 0;
	localparam logic [2:0] RST_CGO = 3'h0;
	localparam logic RST_DENY = 1'h0;
	localparam logic RST_PERMIT = 1'h0;
	localparam logic RST_SLEEP = 1'h1;
	localparam logic RST_CLASS = 1'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Prot bit 1 set marks a non-secure access.
	localparam int PROT_NS_BIT = 1;
	typedef enum logic [1:0] {
		SCRUB_IDLE,
		SCRUB_RUN,
		SCRUB_WAIT
	} rpsc_scrub_t;
endpackage

// File: core/rpsc_top.sv
// Contract
// - Function control takes only secure accesses
// - Scrub covers every RAM of this redistributor
// - Software sets scrub bit, hardware clears it
// - Override field holds one bit per gate
// - Bits: search, downstream, upstream clock gates
// - Deny bit blocks low-power channel when one
// - Read-only cluster interface number field
// - Read-only core index within cluster field
// - Read-only group powered-off status bit
// - Read-only group intent; reached when equal
// - Group apply spreads permit to whole group
// - Group apply ignored if not all accept
// - Permit bit: zero up, one may power down
// - Permit set ignored unless processor sleeping
// - Mismatching write ignored during group transition
// - Last permitting core raises group intent
// - Secure class register selects interrupt class
// - Processor-sleep bit in wake register, read-write
//
// Secure control registers of one redistributor: scrub, clock gate
// overrides, low-power deny and the power permission handshake.
// Assumes the cluster interface power logic drives the group inputs
// on i_mclk and that the scrub engine answers done with a pulse.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module rpsc_top (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [11:0] i_awaddr,
	input wire logic [2:0] i_awprot,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [11:0] i_araddr,
	input wire logic [2:0] i_arprot,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic [8:0] i_cluster_interface_number,
	input wire logic [6:0] i_core_index_in_cluster,
	input wire logic i_others_permit,
	input wire logic i_group_apply_ok,
	input wire logic i_group_power_intent,
	input wire logic i_group_powered_off,
	input wire logic i_scrub_done,
	output logic o_scrub_start,
	output logic [2:0] o_clock_gate_override,
	output logic o_lowpower_channel_deny,
	output logic o_power_down_permit,
	output logic o_group_apply,
	output logic o_group_intent_set,
	output logic o_processor_sleep_flag,
	output logic o_interrupt_class_select
);

////////////////////////////////////////////////////////////////////////////
// Write channel capture. Address and data are taken in either order.

logic aw_held;
logic w_held;
logic [11:0] aw_addr;
logic aw_ns;
logic [31:0] w_data;
logic [3:0] w_strb;
logic wr_fire;
logic wr_sec;

assign wr_fire = aw_held && w_held && !o_bvalid;
assign wr_sec = !aw_ns;

always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		aw_held <= 1'b0;
		aw_addr <= 12'h000;
		aw_ns <= 1'b0;
	end else if (i_awvalid && o_awready) begin
		aw_held <= 1'b1;
		aw_addr <= i_awaddr;
		aw_ns <= i_awprot[rpsc_pkg::PROT_NS_BIT];
	end else if (wr_fire) begin
		aw_held <= 1'b0;
	end
end

always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		w_held <= 1'b0;
		w_data <= 32'h0000_0000;
		w_strb <= 4'h0;
	end else if (i_wvalid && o_wready) begin
		w_held <= 1'b1;
		w_data <= i_wdata;
		w_strb <= i_wstrb;
	end else if (wr_fire) begin
		w_held <= 1'b0;
	end
end

always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_awready <= 1'b0;
	end else begin
		o_awready <= !aw_held && !(i_awvalid && o_awready) && !o_bvalid;
	end
end

always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_wready <= 1'b0;
	end else begin
		o_wready <= !w_held && !(i_wvalid && o_wready) && !o_bvalid;
	end
end

always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_bvalid <= 1'b0;
	end else if (wr_fire) begin
		o_bvalid <= 1'b1;
	end else if (i_bready) begin
		o_bvalid <= 1'b0;
	end
end

// A dropped non-secure write still answers OKAY, so it leaks nothing.
always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_bresp <= rpsc_pkg::RESP_OKAY;
	end else if (wr_fire) begin
		case (aw_addr)
			rpsc_pkg::OFS_FUNCTION_CONTROL,
			rpsc_pkg::OFS_POWER_CONTROL,
			rpsc_pkg::OFS_INTERRUPT_CLASS,
			rpsc_pkg::OFS_WAKE_REGISTER: begin
				o_bresp <= rpsc_pkg::RESP_OKAY;
			end
			default: begin
				o_bresp <= rpsc_pkg::RESP_SLVERR;
			end
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////
// Write address decode and strobes. Writable fields all live in byte 0.

logic wr_hit_fc;
logic wr_hit_pw;
logic wr_hit_cls;
logic wr_hit_wk;
logic wr_byte0;
logic wr_fc;
logic wr_pw;
logic wr_cls;
logic wr_wk;

assign wr_hit_fc = aw_addr == rpsc_pkg::OFS_FUNCTION_CONTROL;
assign wr_hit_pw = aw_addr == rpsc_pkg::OFS_POWER_CONTROL;
assign wr_hit_cls = aw_addr == rpsc_pkg::OFS_INTERRUPT_CLASS;
assign wr_hit_wk = aw_addr == rpsc_pkg::OFS_WAKE_REGISTER;
assign wr_byte0 = wr_fire && w_strb[0];
// The wake register is open to both worlds; the others drop non-secure.
assign wr_fc = wr_byte0 && wr_sec && wr_hit_fc;
assign wr_pw = wr_byte0 && wr_sec && wr_hit_pw;
assign wr_cls = wr_byte0 && wr_sec && wr_hit_cls;
assign wr_wk = wr_byte0 && wr_hit_wk;

////////////////////////////////////////////////////////////////////////////
// Function control: scrub handshake, overrides and deny bit.

rpsc_pkg::rpsc_scrub_t scrub_state;
logic scrub_busy;

assign scrub_busy = scrub_state != rpsc_pkg::SCRUB_IDLE;

// The start pulse goes to one engine that walks every RAM of this
// redistributor; a second start while busy is absorbed, not queued.
always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		scrub_state <= rpsc_pkg::SCRUB_IDLE;
		o_scrub_start <= 1'b0;
	end else begin
		o_scrub_start <= 1'b0;
		case (scrub_state)
			rpsc_pkg::SCRUB_IDLE: begin
				if (wr_fc && w_data[rpsc_pkg::FC_SCRUB_BIT]) begin
					scrub_state <= rpsc_pkg::SCRUB_RUN;
					o_scrub_start <= 1'b1;
				end
			end
			rpsc_pkg::SCRUB_RUN: begin
				scrub_state <= rpsc_pkg::SCRUB_WAIT;
			end
			rpsc_pkg::SCRUB_WAIT: begin
				if (i_scrub_done) begin
					scrub_state <= rpsc_pkg::SCRUB_IDLE;
				end
			end
			default: begin
				scrub_state <= rpsc_pkg::SCRUB_IDLE;
			end
		endcase
	end
end

always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_clock_gate_override <= rpsc_pkg::RST_CGO;
		o_lowpower_channel_deny <= rpsc_pkg::RST_DENY;
	end else if (wr_fc) begin
		o_clock_gate_override <=
			w_data[rpsc_pkg::FC_CGO_HI:rpsc_pkg::FC_CGO_LO];
		o_lowpower_channel_deny <= w_data[rpsc_pkg::FC_DENY_BIT];
	end
end

////////////////////////////////////////////////////////////////////////////
// Wake register sleep flag and class select.

always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_processor_sleep_flag <= rpsc_pkg::RST_SLEEP;
	end else if (wr_wk) begin
		o_processor_sleep_flag <= w_data[rpsc_pkg::WK_SLEEP_BIT];
	end
end

always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_interrupt_class_select <= rpsc_pkg::RST_CLASS;
	end else if (wr_cls) begin
		o_interrupt_class_select <= w_data[rpsc_pkg::CLASS_BIT];
	end
end

////////////////////////////////////////////////////////////////////////////
// Power control: permission bit with its guards, group apply.

logic new_permit;
logic permit_ok;
logic in_transit;

assign new_permit = w_data[rpsc_pkg::PW_PERMIT_BIT];
assign in_transit = i_group_power_intent != i_group_powered_off;
// A set needs the sleep flag; during a group transition only a value
// matching the intent is taken, so the core cannot fight the group.
assign permit_ok = (!new_permit || o_processor_sleep_flag) &&
	!(in_transit && new_permit != i_group_power_intent);

always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_power_down_permit <= rpsc_pkg::RST_PERMIT;
		o_group_intent_set <= 1'b0;
	end else begin
		o_group_intent_set <= 1'b0;
		if (wr_pw && permit_ok) begin
			o_power_down_permit <= new_permit;
			o_group_intent_set <= new_permit && i_others_permit;
		end
	end
end

// The apply pulse carries the permission as it stands after this write.
always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_group_apply <= 1'b0;
	end else begin
		o_group_apply <= wr_pw && w_data[rpsc_pkg::PW_APPLY_BIT] &&
			i_group_apply_ok;
	end
end

////////////////////////////////////////////////////////////////////////////
// Read word of each register. The group apply bit is write-only.

logic [31:0] fc_word;
logic [31:0] pw_word;
logic [31:0] cls_word;
logic [31:0] wk_word;

always_comb begin
	fc_word = 32'h0000_0000;
	fc_word[rpsc_pkg::FC_SCRUB_BIT] = scrub_busy;
	fc_word[rpsc_pkg::FC_DENY_BIT] = o_lowpower_channel_deny;
	fc_word[rpsc_pkg::FC_CGO_HI:rpsc_pkg::FC_CGO_LO] =
		o_clock_gate_override;
end

always_comb begin
	pw_word = 32'h0000_0000;
	pw_word[rpsc_pkg::PW_PERMIT_BIT] = o_power_down_permit;
	pw_word[rpsc_pkg::PW_INTENT_BIT] = i_group_power_intent;
	pw_word[rpsc_pkg::PW_OFF_BIT] = i_group_powered_off;
	pw_word[rpsc_pkg::PW_CORE_HI:rpsc_pkg::PW_CORE_LO] =
		i_core_index_in_cluster;
	pw_word[rpsc_pkg::PW_GRP_HI:rpsc_pkg::PW_GRP_LO] =
		i_cluster_interface_number;
end

always_comb begin
	cls_word = 32'h0000_0000;
	cls_word[rpsc_pkg::CLASS_BIT] = o_interrupt_class_select;
end

always_comb begin
	wk_word = 32'h0000_0000;
	wk_word[rpsc_pkg::WK_SLEEP_BIT] = o_processor_sleep_flag;
end

////////////////////////////////////////////////////////////////////////////
// Read channel.

logic [31:0] rd_word;
logic rd_ok;

always_comb begin
	rd_word = 32'h0000_0000;
	rd_ok = 1'b1;
	case (i_araddr)
		rpsc_pkg::OFS_FUNCTION_CONTROL: begin
			rd_word = fc_word;
		end
		rpsc_pkg::OFS_POWER_CONTROL: begin
			rd_word = pw_word;
		end
		rpsc_pkg::OFS_INTERRUPT_CLASS: begin
			rd_word = cls_word;
		end
		rpsc_pkg::OFS_WAKE_REGISTER: begin
			rd_word = wk_word;
		end
		default: begin
			rd_ok = 1'b0;
		end
	endcase
	if (i_arprot[rpsc_pkg::PROT_NS_BIT] &&
		i_araddr != rpsc_pkg::OFS_WAKE_REGISTER) begin
		rd_word = 32'h0000_0000;
	end
end

always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_arready <= 1'b0;
	end else if (i_arvalid && o_arready) begin
		o_arready <= 1'b0;
	end else if (!o_rvalid) begin
		o_arready <= 1'b1;
	end
end

always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_rvalid <= 1'b0;
	end else if (i_arvalid && o_arready) begin
		o_rvalid <= 1'b1;
	end else if (i_rready) begin
		o_rvalid <= 1'b0;
	end
end

// Data and response hold until the handshake, as the bus requires.
always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		o_rdata <= 32'h0000_0000;
		o_rresp <= rpsc_pkg::RESP_OKAY;
	end else if (i_arvalid && o_arready) begin
		o_rdata <= rd_word;
		o_rresp <= rd_ok ? rpsc_pkg::RESP_OKAY : rpsc_pkg::RESP_SLVERR;
	end
end

endmodule // rpsc_top

// File: verification/rpsc_monitor.sv
// Checker of rpsc_top pulses and register updates.
// Sees only top ports; bound to rpsc_top below.
`timescale 1ns/1ps
module rpsc_monitor (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic o_bvalid,
	input wire logic i_others_permit,
	input wire logic i_group_apply_ok,
	input wire logic o_scrub_start,
	input wire logic [2:0] o_clock_gate_override,
	input wire logic o_lowpower_channel_deny,
	input wire logic o_power_down_permit,
	input wire logic o_group_apply,
	input wire logic o_group_intent_set,
	input wire logic o_processor_sleep_flag
);
default clocking cb @(posedge i_mclk); endclocking
default disable iff (!i_rst_b);
a_start_pulse: assert property (o_scrub_start |=> !o_scrub_start)
	else $error("scrub start too long");
a_start_on_b: assert property (o_scrub_start |-> $rose(o_bvalid))
	else $error("scrub start off the write");
a_apply_on_b: assert property (o_group_apply |-> $rose(o_bvalid))
	else $error("group apply off the write");
a_apply_pulse: assert property (o_group_apply |=> !o_group_apply)
	else $error("group apply too long");
a_apply_ok: assert property (o_group_apply |-> $past(i_group_apply_ok))
	else $error("group apply not allowed");
a_intent_cause: assert property (o_group_intent_set |->
	o_power_down_permit && $past(i_others_permit) && $rose(o_bvalid))
	else $error("intent set without cause");
a_permit_sleep: assert property ($rose(o_power_down_permit) |->
	$past(o_processor_sleep_flag)) else $error("permit set while awake");
a_state_by_write: assert property ($changed({o_clock_gate_override,
	o_lowpower_channel_deny, o_power_down_permit}) |-> $rose(o_bvalid))
	else $error("state changed outside a write");
c_scrub: cover property (o_scrub_start);
c_apply: cover property (o_group_apply);
c_intent: cover property (o_group_intent_set);
endmodule // rpsc_monitor
////////////////////////////////////////
bind rpsc_top rpsc_monitor i_mon (.*);

// File: verification/rpsc_far_model.sv
// Far side: scrub engine and cluster interface power logic.
// Assumes one-cycle pulses from the block on i_mclk.
`timescale 1ns/1ps
module rpsc_far_model #(parameter int DLY = 12) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_scrub_start,
	input wire logic i_intent_set,
	input wire logic i_group_apply,
	input wire logic i_permit,
	output logic o_scrub_done,
	output logic o_intent,
	output logic o_off
);
int sc;
int pc;
// DLY stands in for the sweep of every RAM, kept short for run time.
always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		sc <= 0;
		o_scrub_done <= 1'b0;
	end else begin
		o_scrub_done <= (sc == 1);
		sc <= i_scrub_start ? DLY : (sc > 0 ? sc - 1 : 0);
	end
end
// Off status trails intent, so a transition window is seen.
always_ff @(posedge i_mclk or negedge i_rst_b) begin
	if (!i_rst_b) begin
		{o_intent, o_off, pc} <= '0;
	end else begin
		if (i_intent_set || i_group_apply)
			o_intent <= i_intent_set | i_permit;
		pc <= (o_intent != o_off) ? pc + 1 : 0;
		if (pc == DLY)
			o_off <= o_intent;
	end
end
endmodule // rpsc_far_model

// File: verification/rpsc_top_test.sv
// Bench of rpsc_top over AXI4-Lite with directed register tests.
// The far side is rpsc_far_model; reset is held three cycles.
`timescale 1ns/1ps
module rpsc_top_test;
logic i_mclk = 1'b0, i_rst_b = 1'b0;
logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
logic [2:0] i_awprot = 3'h0, i_arprot = 3'h0;
logic [31:0] i_wdata = 32'h0, rdat, o_rdata;
logic [3:0] i_wstrb = 4'hf;
logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
logic i_arvalid = 1'b0, i_rready = 1'b0;
logic i_others_permit = 1'b0, i_group_apply_ok = 1'b0;
logic [8:0] i_cluster_interface_number = 9'h15a;
logic [6:0] i_core_index_in_cluster = 7'h2b;
logic i_group_power_intent, i_group_powered_off, i_scrub_done;
logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_scrub_start;
logic [1:0] o_bresp, o_rresp, rrsp, brsp;
logic [2:0] o_clock_gate_override;
logic o_lowpower_channel_deny, o_power_down_permit, o_group_apply;
logic o_group_intent_set, o_processor_sleep_flag, o_interrupt_class_select;
int n_fail = 0, num_checks = 0, nscrub = 0, napply = 0, nint = 0, i, k;
rpsc_top i_dut (.*);
rpsc_far_model i_far (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
	.i_scrub_start(o_scrub_start), .i_intent_set(o_group_intent_set),
	.i_group_apply(o_group_apply), .i_permit(o_power_down_permit),
	.o_scrub_done(i_scrub_done), .o_intent(i_group_power_intent),
	.o_off(i_group_powered_off));
initial begin
	forever #25 i_mclk = ~i_mclk;
end
// Pulses are counted mid-cycle, where they have settled.
always @(negedge i_mclk) begin
	nscrub += (o_scrub_start === 1'b1);
	napply += (o_group_apply === 1'b1);
	nint += (o_group_intent_set === 1'b1);
end
task automatic chk(input logic [31:0] g, input logic [31:0] e);
	num_checks++;
	if (g !== e) begin
		n_fail++;
		$display("ERROR %0t got %h expected %h", $time, g, e);
	end
endtask
task automatic conclude(input bit hang);
	if (hang) chk(32'h1, 32'h0);
	$display("checks %0d mismatches %0d", num_checks, n_fail);
	if (n_fail == 0 && num_checks > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
task automatic wr(input logic [11:0] a, input logic [31:0] d, input bit ns);
	int n;
	@(posedge i_mclk);
	i_awaddr <= a;
	i_awprot <= {1'b0, ns, 1'b0};
	i_wdata <= d;
	i_awvalid <= 1'b1;
	i_wvalid <= 1'b1;
	i_bready <= 1'b1;
	for (n = 0; n < 40 && o_bvalid !== 1'b1; n++) begin
		@(posedge i_mclk);
		if (o_awready === 1'b1) i_awvalid <= 1'b0;
		if (o_wready === 1'b1) i_wvalid <= 1'b0;
	end
	brsp = o_bresp;
	i_bready <= 1'b0;
	if (n == 40) conclude(1'b1);
endtask
task automatic rd(input logic [11:0] a, input bit ns);
	int n;
	@(posedge i_mclk);
	i_araddr <= a;
	i_arprot <= {1'b0, ns, 1'b0};
	i_arvalid <= 1'b1;
	i_rready <= 1'b1;
	for (n = 0; n < 40 && o_rvalid !== 1'b1; n++) begin
		@(posedge i_mclk);
		if (o_arready === 1'b1) i_arvalid <= 1'b0;
	end
	rdat = o_rdata;
	rrsp = o_rresp;
	i_rready <= 1'b0;
	if (n == 40) conclude(1'b1);
endtask
////////////////////////////////////////
initial begin
	repeat (3) @(posedge i_mclk);
	i_rst_b <= 1'b1;
	rd(12'h004, 1'b0);
	chk(rdat, {8'h0, 9'h15a, 7'h2b, 8'h0});
	rd(12'h00c, 1'b0);
	chk(rdat, 32'h2);
	$display("reset test done");
	for (i = 0; i < 3; i++) begin
		wr(12'h000, 32'hffffffe2 | (32'h4 << i), 1'b0);
		chk(32'(o_lowpower_channel_deny), 32'h1);
		rd(12'h000, 1'b0);
		chk(rdat, 32'h2 | (32'h4 << i));
		chk(32'(o_clock_gate_override), 32'h1 << i);
	end
	wr(12'h000, 32'h1d, 1'b1);
	chk(32'(brsp), 32'h0);
	rd(12'h000, 1'b1);
	chk(rdat, 32'h0);
	rd(12'h000, 1'b0);
	chk(rdat, 32'h12);
	rd(12'h010, 1'b0);
	chk(32'(rrsp), 32'h2);
	wr(12'h010, 32'h0, 1'b0);
	chk(32'(brsp), 32'h2);
	$display("access test done");
	wr(12'h000, 32'h1, 1'b0);
	chk(32'(o_lowpower_channel_deny), 32'h0);
	rd(12'h000, 1'b0);
	chk(rdat, 32'h1);
	wr(12'h000, 32'h1, 1'b0);
	for (k = 0; k < 20 && rdat[0] !== 1'b0; k++)
		rd(12'h000, 1'b0);
	chk(rdat, 32'h0);
	chk(32'(nscrub), 32'h1);
	$display("scrub test done");
	wr(12'h008, 32'h1, 1'b0);
	chk(32'(o_interrupt_class_select), 32'h1);
	wr(12'h008, 32'h0, 1'b1);
	rd(12'h008, 1'b0);
	chk(rdat, 32'h1);
	rd(12'h008, 1'b1);
	chk(rdat, 32'h0);
	$display("class test done");
	wr(12'h00c, 32'h0, 1'b0);
	wr(12'h004, 32'h1, 1'b0);
	chk(32'(o_power_down_permit), 32'h0);
	wr(12'h00c, 32'h2, 1'b0);
	wr(12'h004, 32'h1, 1'b0);
	chk(32'(o_power_down_permit), 32'h1);
	wr(12'h004, 32'h0, 1'b0);
	i_others_permit <= 1'b1;
	wr(12'h004, 32'h1, 1'b0);
	wr(12'h004, 32'h0, 1'b0);
	chk(32'(o_power_down_permit), 32'h1);
	chk(32'(nint), 32'h1);
	for (k = 0; k < 20 && rdat[3] !== 1'b1; k++)
		rd(12'h004, 1'b0);
	chk(32'(rdat[3:2]), 32'h3);
	wr(12'h004, 32'h0, 1'b0);
	chk(32'(o_power_down_permit), 32'h0);
	wr(12'h004, 32'h2, 1'b0);
	chk(32'(napply), 32'h0);
	i_group_apply_ok <= 1'b1;
	wr(12'h004, 32'h2, 1'b1);
	wr(12'h004, 32'h2, 1'b0);
	chk(32'(napply), 32'h1);
	$display("power test done");
	conclude(1'b0);
end
endmodule // rpsc_top_test
